// ---- src/odm_pkg.sv ----
package odm_pkg;

  // APB register map, byte addresses of aligned 32-bit words.
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_SEL    = 8'h04;
  localparam logic [7:0] OFF_POL    = 8'h08;
  localparam logic [7:0] OFF_DLY0   = 8'h0C;
  localparam logic [7:0] OFF_DLY1   = 8'h10;
  localparam logic [7:0] OFF_DLY2   = 8'h14;
  localparam logic [7:0] OFF_DLY3   = 8'h18;
  localparam logic [7:0] OFF_PWR_TH = 8'h1C;
  localparam logic [7:0] OFF_T_DUR  = 8'h20;
  localparam logic [7:0] OFF_R_LIM  = 8'h24;
  localparam logic [7:0] OFF_AI_WIN = 8'h28;
  localparam logic [7:0] OFF_TEMP   = 8'h2C;
  localparam logic [7:0] OFF_SRC    = 8'h30;
  localparam logic [7:0] OFF_AO1    = 8'h34;
  localparam logic [7:0] OFF_AO2    = 8'h38;
  localparam logic [7:0] OFF_FMAX   = 8'h3C;
  localparam logic [7:0] OFF_STAT   = 8'h40;

  // Field positions.
  localparam int unsigned CTRL_PULSE_BIT = 0;
  localparam int unsigned CTRL_TIMER_BIT = 1;
  localparam int unsigned SEL_W          = 6;
  localparam int unsigned SEL_STRIDE     = 8;
  localparam int unsigned POL_DIGIT_W    = 4;
  localparam int unsigned HI_FIELD_LSB   = 16;
  localparam int unsigned SRC_W          = 4;
  localparam int unsigned LVL_W          = 10;
  localparam int unsigned NUM_SRC        = 16;
  localparam int unsigned NUM_TERM       = 4;

  // Output function selector codes.
  localparam logic [5:0] SEL_NONE     = 6'h00;
  localparam logic [5:0] SEL_PWR_ON   = 6'h18;
  localparam logic [5:0] SEL_FREQ1    = 6'h1A;
  localparam logic [5:0] SEL_FREQ2    = 6'h1B;
  localparam logic [5:0] SEL_CUR1     = 6'h1C;
  localparam logic [5:0] SEL_CUR2     = 6'h1D;
  localparam logic [5:0] SEL_TIMING   = 6'h1E;
  localparam logic [5:0] SEL_AI_WIN   = 6'h1F;
  localparam logic [5:0] SEL_LOAD0    = 6'h20;
  localparam logic [5:0] SEL_REVERSE  = 6'h21;
  localparam logic [5:0] SEL_MOD_TEMP = 6'h23;
  localparam logic [5:0] SEL_LOW_HOLD = 6'h25;
  localparam logic [5:0] SEL_ALARM    = 6'h26;
  localparam logic [5:0] SEL_MOT_HOT  = 6'h27;
  localparam logic [5:0] SEL_RUN_TIME = 6'h28;
  localparam logic [5:0] SEL_MAX      = 6'h28;

  // Polarity digit values.
  localparam logic [3:0] POL_NEGATIVE = 4'h1;

  // Reset values.
  localparam logic [5:0]  SEL_RST_FAST  = 6'h00;
  localparam logic [5:0]  SEL_RST_RLY1  = 6'h02;
  localparam logic [5:0]  SEL_RST_RLY2  = 6'h00;
  localparam logic [5:0]  SEL_RST_OC    = 6'h01;
  localparam logic [3:0]  SRC_RST_AO1   = 4'h0;
  localparam logic [3:0]  SRC_RST_AO2   = 4'h1;
  localparam logic [3:0]  SRC_RST_PULSE = 4'h0;
  localparam logic [15:0] GAIN_RST      = 16'h0064;
  localparam logic [15:0] FMAX_RST      = 16'h1388;

  // Limits: delay in 0.1 s, gain in 0.01, offset and levels in 0.1 %, frequency in 0.01 kHz.
  localparam logic [15:0] DLY_MAX    = 16'h8CA0;
  localparam logic [15:0] GAIN_LIM   = 16'h03E8;
  localparam logic [15:0] OFFS_LIM   = 16'h03E8;
  localparam logic [9:0]  FULL_SCALE = 10'h3E8;
  localparam logic [15:0] FMAX_MIN   = 16'h0001;
  localparam logic [15:0] FMAX_LIM   = 16'h2710;
  localparam int          GAIN_UNIT  = 100;

  // Timing.
  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned CLK_NS          = 8;
  localparam int unsigned DLY_TICK_NS     = 100_000_000;
  localparam int unsigned DLY_TICK_CYCLES = DLY_TICK_NS / CLK_NS;
  localparam int unsigned FREQ_STEP_HZ    = 10;
  localparam longint unsigned PHASE_FULL  = 64'h0000_0001_0000_0000;
  localparam logic [8:0]  PHASE_INC       = 9'((FREQ_STEP_HZ * PHASE_FULL) / CLK_HZ);

endpackage

// ---- src/odm_top.sv ----
// How it works
// - Code 24: on when power-on hours exceed the power-on threshold.
// - Codes 26 and 27 pass frequency-reached flags one and two.
// - Codes 28 and 29 pass current-reached flags one and two.
// - Code 30: on when timing enabled and run time reached set duration.
// - Code 31: on when analog input one is outside its window.
// - Code 32: on while the detected load is zero.
// - Code 33: on while running in reverse.
// - Code 35: on when module heatsink temperature reaches its threshold.
// - Code 37: on at lower frequency limit, and held on while stopped.
// - Code 38: on when a fault occurs while the drive keeps running.
// - Code 39: on when motor temperature reaches the overheat warning level.
// - Code 40: on when present run time exceeds the run-time limit.
// - One polarity digit per terminal; 0 positive, 1 negative logic.
// - Positive: active closes to common; negative: active opens it.
// - Each terminal delays status changes by 0.0 s to 3600.0 s.
// - Pulse output spans 0.01 kHz to a maximum held within 0.01-100 kHz.
// - Sources 0 to 6 are frequencies, current, voltage, speed, torque, power.
// - Sources 7 to 15 are pulse, analog inputs, length, count, link, current, voltage.
// - Analog output is gain times standard output plus offset, gain within +-10.00.
// - Offset within +-100.0 %, where 100 % is full-scale output.
// - Code 0 gives no function; the output is never active.
// - Pulse maximum frequency resets to 50.00 kHz.
`timescale 1ns/1ps
`default_nettype none
module odm_top #(
  parameter int unsigned TICK_CYCLES = odm_pkg::DLY_TICK_CYCLES
) (
  // Clock and reset
  input  wire  logic                         pclk,
  input  wire  logic                         presetn,
  // APB slave
  input  wire  logic                         psel,
  input  wire  logic                         penable,
  input  wire  logic                         pwrite,
  input  wire  logic [odm_pkg::ADDR_W-1:0]   paddr,
  input  wire  logic [31:0]                  pwdata,
  output logic       [31:0]                  prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Drive status
  input  wire  logic [15:0]                  power_on_hours,
  input  wire  logic [15:0]                  run_time_now,
  input  wire  logic                         freq_one_reached,
  input  wire  logic                         freq_two_reached,
  input  wire  logic                         current_one_reached,
  input  wire  logic                         current_two_reached,
  input  wire  logic [odm_pkg::LVL_W-1:0]    analog_in_one,
  input  wire  logic                         load_is_zero,
  input  wire  logic                         reverse_running,
  input  wire  logic [7:0]                   module_temp,
  input  wire  logic                         freq_at_lower_limit,
  input  wire  logic                         drive_stopped,
  input  wire  logic                         fault_keep_running,
  input  wire  logic [7:0]                   motor_temp,
  input  wire  logic [odm_pkg::SEL_MAX:0]    other_condition,
  // Analog and pulse source levels, 16 fields of 0.1 % each
  input  wire  logic [odm_pkg::NUM_SRC*odm_pkg::LVL_W-1:0] source_level,
  // Terminals, high means closed to common
  output logic                               fast_pulse_output_pin,
  output logic                               relay_one_output,
  output logic                               relay_two_output,
  output logic                               open_collector_output,
  // Analog outputs in 0.1 % of full scale
  output logic       [odm_pkg::LVL_W-1:0]    analog_out_one,
  output logic       [odm_pkg::LVL_W-1:0]    analog_out_two
);
  import odm_pkg::*;

  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least one");
  end

  localparam int unsigned TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  function automatic logic signed [15:0] sat_sym(input logic [15:0] v, input logic [15:0] lim);
    logic signed [15:0] s;
    s = $signed(v);
    if (s > $signed(lim)) begin
      return $signed(lim);
    end else if (s < -$signed(lim)) begin
      return -$signed(lim);
    end
    return s;
  endfunction

  function automatic logic [15:0] clamp_u(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction

  function automatic logic [LVL_W-1:0] pick(input logic [NUM_SRC*LVL_W-1:0] bus, input logic [SRC_W-1:0] s);
    return bus[s*LVL_W +: LVL_W];
  endfunction

  // Configuration registers
  logic                      pulse_mode_r;
  logic                      timer_en_r;
  logic [SEL_W-1:0]          sel_r [NUM_TERM];
  logic [15:0]               pol_r;
  logic [15:0]               dly_r [NUM_TERM];
  logic [15:0]               pwr_th_r;
  logic [15:0]               t_dur_r;
  logic [15:0]               r_lim_r;
  logic [LVL_W-1:0]          ai_lo_r;
  logic [LVL_W-1:0]          ai_hi_r;
  logic [7:0]                mod_th_r;
  logic [7:0]                mot_th_r;
  logic [SRC_W-1:0]          ao_src_r [2];
  logic [SRC_W-1:0]          pls_src_r;
  logic signed [15:0]        gain_r [2];
  logic signed [15:0]        offs_r [2];
  logic [15:0]               fmax_r;

  // Bus and state
  logic [31:0]               rd_nxt;
  logic                      err_nxt;
  logic                      wr_en;
  logic [NUM_TERM-1:0]       cond;
  logic [NUM_TERM-1:0]       term_r;
  logic [NUM_TERM-1:0]       neg;
  logic [NUM_TERM-1:0]       pin_r;
  logic [TW-1:0]             tick_cnt_r;
  logic                      tick;
  logic [15:0]               dcnt_r [NUM_TERM];
  logic [31:0]               phase_r;
  logic [15:0]               freq_code;
  logic [25:0]               freq_prod;

  // One wait state: pready rises in the second access cycle, so data and error come from flops.
  assign wr_en = psel && penable && pready && pwrite && !err_nxt;

  always_comb begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    case (paddr)
      OFF_CTRL:   rd_nxt = {30'h0000_0000, timer_en_r, pulse_mode_r};
      OFF_SEL:    rd_nxt = {2'h0, sel_r[3], 2'h0, sel_r[2], 2'h0, sel_r[1], 2'h0, sel_r[0]};
      OFF_POL:    rd_nxt = {16'h0000, pol_r};
      OFF_DLY0:   rd_nxt = {16'h0000, dly_r[0]};
      OFF_DLY1:   rd_nxt = {16'h0000, dly_r[1]};
      OFF_DLY2:   rd_nxt = {16'h0000, dly_r[2]};
      OFF_DLY3:   rd_nxt = {16'h0000, dly_r[3]};
      OFF_PWR_TH: rd_nxt = {16'h0000, pwr_th_r};
      OFF_T_DUR:  rd_nxt = {16'h0000, t_dur_r};
      OFF_R_LIM:  rd_nxt = {16'h0000, r_lim_r};
      OFF_AI_WIN: rd_nxt = {6'h00, ai_hi_r, 6'h00, ai_lo_r};
      OFF_TEMP:   rd_nxt = {16'h0000, mot_th_r, mod_th_r};
      OFF_SRC:    rd_nxt = {20'h00000, pls_src_r, ao_src_r[1], ao_src_r[0]};
      OFF_AO1:    rd_nxt = {offs_r[0], gain_r[0]};
      OFF_AO2:    rd_nxt = {offs_r[1], gain_r[1]};
      OFF_FMAX:   rd_nxt = {16'h0000, fmax_r};
      OFF_STAT:   rd_nxt = {20'h00000, pin_r, term_r, cond};
      default:    err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= (psel && penable && !pready && !pwrite) ? rd_nxt : 32'h0000_0000;
      pslverr <= psel && penable && !pready && err_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_mode_r <= 1'b0;
      timer_en_r   <= 1'b0;
      sel_r[0]     <= SEL_RST_FAST;
      sel_r[1]     <= SEL_RST_RLY1;
      sel_r[2]     <= SEL_RST_RLY2;
      sel_r[3]     <= SEL_RST_OC;
      pol_r        <= 16'h0000;
      pwr_th_r     <= 16'h0000;
      t_dur_r      <= 16'h0000;
      r_lim_r      <= 16'h0000;
      ai_lo_r      <= 10'h000;
      ai_hi_r      <= FULL_SCALE;
      mod_th_r     <= 8'h00;
      mot_th_r     <= 8'h00;
      ao_src_r[0]  <= SRC_RST_AO1;
      ao_src_r[1]  <= SRC_RST_AO2;
      pls_src_r    <= SRC_RST_PULSE;
      gain_r[0]    <= GAIN_RST;
      gain_r[1]    <= GAIN_RST;
      offs_r[0]    <= 16'h0000;
      offs_r[1]    <= 16'h0000;
      fmax_r       <= FMAX_RST;
      for (int i = 0; i < NUM_TERM; i++) begin
        dly_r[i] <= 16'h0000;
      end
    end else if (wr_en) begin
      case (paddr)
        OFF_CTRL: begin
          pulse_mode_r <= pwdata[CTRL_PULSE_BIT];
          timer_en_r   <= pwdata[CTRL_TIMER_BIT];
        end
        OFF_SEL: begin
          for (int i = 0; i < NUM_TERM; i++) begin
            sel_r[i] <= pwdata[i*SEL_STRIDE +: SEL_W];
          end
        end
        OFF_POL:    pol_r    <= pwdata[15:0];
        OFF_DLY0:   dly_r[0] <= clamp_u(pwdata[15:0], 16'h0000, DLY_MAX);
        OFF_DLY1:   dly_r[1] <= clamp_u(pwdata[15:0], 16'h0000, DLY_MAX);
        OFF_DLY2:   dly_r[2] <= clamp_u(pwdata[15:0], 16'h0000, DLY_MAX);
        OFF_DLY3:   dly_r[3] <= clamp_u(pwdata[15:0], 16'h0000, DLY_MAX);
        OFF_PWR_TH: pwr_th_r <= pwdata[15:0];
        OFF_T_DUR:  t_dur_r  <= pwdata[15:0];
        OFF_R_LIM:  r_lim_r  <= pwdata[15:0];
        OFF_AI_WIN: begin
          ai_lo_r <= pwdata[LVL_W-1:0];
          ai_hi_r <= pwdata[HI_FIELD_LSB +: LVL_W];
        end
        OFF_TEMP: begin
          mod_th_r <= pwdata[7:0];
          mot_th_r <= pwdata[15:8];
        end
        OFF_SRC: begin
          ao_src_r[0] <= pwdata[SRC_W-1:0];
          ao_src_r[1] <= pwdata[2*SRC_W-1:SRC_W];
          pls_src_r   <= pwdata[3*SRC_W-1:2*SRC_W];
        end
        OFF_AO1: begin
          gain_r[0] <= sat_sym(pwdata[15:0], GAIN_LIM);
          offs_r[0] <= sat_sym(pwdata[31:16], OFFS_LIM);
        end
        OFF_AO2: begin
          gain_r[1] <= sat_sym(pwdata[15:0], GAIN_LIM);
          offs_r[1] <= sat_sym(pwdata[31:16], OFFS_LIM);
        end
        OFF_FMAX:   fmax_r <= clamp_u(pwdata[15:0], FMAX_MIN, FMAX_LIM);
        default: begin
        end
      endcase
    end
  end

  // A shared 0.1 s prescaler keeps the four delays cheap; a delay can run up to one tick short.
  assign tick = (tick_cnt_r == TW'(TICK_CYCLES - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end

  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    always_comb begin
      case (sel_r[t])
        SEL_NONE:     cond[t] = 1'b0;
        SEL_PWR_ON:   cond[t] = power_on_hours > pwr_th_r;
        SEL_FREQ1:    cond[t] = freq_one_reached;
        SEL_FREQ2:    cond[t] = freq_two_reached;
        SEL_CUR1:     cond[t] = current_one_reached;
        SEL_CUR2:     cond[t] = current_two_reached;
        SEL_TIMING:   cond[t] = timer_en_r && (run_time_now >= t_dur_r);
        SEL_AI_WIN:   cond[t] = (analog_in_one > ai_hi_r) || (analog_in_one < ai_lo_r);
        SEL_LOAD0:    cond[t] = load_is_zero;
        SEL_REVERSE:  cond[t] = reverse_running;
        SEL_MOD_TEMP: cond[t] = module_temp >= mod_th_r;
        SEL_LOW_HOLD: cond[t] = freq_at_lower_limit || drive_stopped;
        SEL_ALARM:    cond[t] = fault_keep_running;
        SEL_MOT_HOT:  cond[t] = motor_temp >= mot_th_r;
        SEL_RUN_TIME: cond[t] = run_time_now > r_lim_r;
        default:      cond[t] = (sel_r[t] <= SEL_MAX) && other_condition[sel_r[t]];
      endcase
    end

    // Any digit other than the negative code is taken as positive logic.
    assign neg[t] = (pol_r[t*POL_DIGIT_W +: POL_DIGIT_W] == POL_NEGATIVE);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        term_r[t] <= 1'b0;
        dcnt_r[t] <= 16'h0000;
      end else if (cond[t] == term_r[t]) begin
        dcnt_r[t] <= 16'h0000;
      end else if (dcnt_r[t] >= dly_r[t]) begin
        term_r[t] <= cond[t];
        dcnt_r[t] <= 16'h0000;
      end else if (tick) begin
        dcnt_r[t] <= dcnt_r[t] + 16'h0001;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pin_r[t] <= 1'b0;
      end else begin
        pin_r[t] <= term_r[t] ^ neg[t];
      end
    end
  end

  assign relay_one_output      = pin_r[1];
  assign relay_two_output      = pin_r[2];
  assign open_collector_output = pin_r[3];

  // The pulse frequency is the lowest step plus the source fraction of the span to the maximum.
  assign freq_prod = 26'(pick(source_level, pls_src_r)) * 26'(fmax_r - FMAX_MIN);
  assign freq_code = FMAX_MIN + 16'(freq_prod / 26'(FULL_SCALE));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 32'h0000_0000;
    end else begin
      phase_r <= phase_r + 32'(freq_code * PHASE_INC);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_pulse_output_pin <= 1'b0;
    end else if (pulse_mode_r) begin
      fast_pulse_output_pin <= phase_r[31];
    end else begin
      fast_pulse_output_pin <= pin_r[0];
    end
  end

  for (genvar a = 0; a < 2; a++) begin : g_ao
    logic [LVL_W-1:0]   x;
    logic signed [27:0] prod;
    logic signed [27:0] y;
    logic [LVL_W-1:0]   y_sat;
    logic [LVL_W-1:0]   ao_r;

    assign x    = pick(source_level, ao_src_r[a]);
    assign prod = 28'(gain_r[a]) * $signed({18'h00000, x});
    assign y    = prod / 28'(GAIN_UNIT) + 28'(offs_r[a]);

    always_comb begin
      if (y < 28'sh0000000) begin
        y_sat = 10'h000;
      end else if (y > $signed({18'h00000, FULL_SCALE})) begin
        y_sat = FULL_SCALE;
      end else begin
        y_sat = y[LVL_W-1:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ao_r <= 10'h000;
      end else begin
        ao_r <= y_sat;
      end
    end
  end

  assign analog_out_one = g_ao[0].ao_r;
  assign analog_out_two = g_ao[1].ao_r;

endmodule
`default_nettype wire

// ---- bench/odm_term_load.sv ----
`timescale 1ns/1ps
`default_nettype none
module odm_term_load (
  // Clock
  input  wire logic       pclk,
  // Terminal pins, high when closed to common
  input  wire logic       fast_pin,
  input  wire logic       relay_one,
  input  wire logic       relay_two,
  input  wire logic       open_coll,
  // Contact state seen by the equipment, bit 0 fast to bit 3 open collector
  output logic      [3:0] closed
);
  // Contacts are latched on the clock so that a glitch between edges never counts as a closure.
  always_ff @(posedge pclk) begin
    closed <= {open_coll, relay_two, relay_one, fast_pin};
  end
endmodule
`default_nettype wire

// ---- bench/odm_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module odm_checker (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Analog outputs
  input wire logic [9:0]  analog_out_one,
  input wire logic [9:0]  analog_out_two
);
  import odm_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_one_wait_state: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  a_ready_single: assert property (pready |=> !pready) else $error("pready stretched");
  a_ready_in_access: assert property (pready |-> psel && penable) else $error("pready outside access");
  a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
  a_err_unmapped: assert property (pready && (paddr > OFF_STAT || paddr[1:0] != 2'h0) |-> pslverr)
    else $error("unmapped not refused");
  a_ok_mapped: assert property (pready && paddr <= OFF_STAT && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped refused");
  a_ao_one_clamp: assert property (analog_out_one <= FULL_SCALE) else $error("ao1 over scale");
  a_ao_two_clamp: assert property (analog_out_two <= FULL_SCALE) else $error("ao2 over scale");
endmodule
bind odm_top odm_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .analog_out_one(analog_out_one),
  .analog_out_two(analog_out_two));
`default_nettype wire

// ---- bench/tb_drive_output_terminal_mapper.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_drive_output_terminal_mapper;
  import odm_pkg::*;
  typedef struct packed {logic [5:0] code; logic exp;} odm_row_t;
  typedef struct packed {logic [7:0] a; logic [31:0] v;} odm_reg_t;
  typedef struct packed {logic [31:0] cfg; logic [9:0] x; logic [9:0] y;} odm_ao_t;
  localparam int unsigned TICK = 4;
  localparam odm_row_t ROWS [15] = '{'{SEL_NONE, 1'b0}, '{SEL_PWR_ON, 1'b1}, '{SEL_FREQ1, 1'b1},
    '{SEL_FREQ2, 1'b1}, '{SEL_CUR1, 1'b1}, '{SEL_CUR2, 1'b1}, '{SEL_TIMING, 1'b1}, '{SEL_AI_WIN, 1'b1},
    '{SEL_LOAD0, 1'b1}, '{SEL_REVERSE, 1'b1}, '{SEL_MOD_TEMP, 1'b1}, '{SEL_LOW_HOLD, 1'b1},
    '{SEL_ALARM, 1'b1}, '{SEL_MOT_HOT, 1'b1}, '{SEL_RUN_TIME, 1'b1}};
  localparam odm_reg_t RST [6] = '{'{OFF_SEL, 32'h01000200}, '{OFF_SRC, 32'h00000010},
    '{OFF_AO1, 32'h00000064}, '{OFF_AO2, 32'h00000064}, '{OFF_FMAX, 32'h00001388}, '{OFF_DLY0, 32'h0}};
  localparam odm_ao_t AOS [5] = '{'{32'h00000064, 10'h1F4, 10'h1F4}, '{32'h0320FFCE, 10'h3E8, 10'h12C},
    '{32'h000003E8, 10'h0C8, 10'h3E8}, '{32'hFC180064, 10'h1F4, 10'h000}, '{32'h7FFFFF9C, 10'h1F4, 10'h1F4}};
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic [7:0]   paddr = 8'h00;
  logic [31:0]  pwdata = 32'h0;
  logic [31:0]  prdata;
  logic [31:0]  rd;
  logic         pready;
  logic         pslverr;
  logic         err;
  logic [15:0]  hours = 16'h0;
  logic [15:0]  run_now = 16'h0;
  logic [6:0]   flags = 7'h0;
  logic [9:0]   ain = 10'h0;
  logic [7:0]   mod_t = 8'h0;
  logic [7:0]   mot_t = 8'h0;
  logic [159:0] src_lvl = '0;
  logic [9:0]   ao1;
  logic [9:0]   ao2;
  logic         fp;
  logic         r1;
  logic         r2;
  logic         oc;
  logic [3:0]   closed;
  int           fail_count = 0;
  int           num_checks = 0;
  int           n;
  int           m;

  always #4 pclk = ~pclk;

  odm_top #(.TICK_CYCLES(TICK)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .power_on_hours(hours), .run_time_now(run_now), .freq_one_reached(flags[0]), .freq_two_reached(flags[1]),
    .current_one_reached(flags[2]), .current_two_reached(flags[3]), .analog_in_one(ain),
    .load_is_zero(flags[4]), .reverse_running(flags[5]), .module_temp(mod_t), .freq_at_lower_limit(flags[6]),
    .drive_stopped(flags[5]), .fault_keep_running(flags[4]), .motor_temp(mot_t), .other_condition('0),
    .source_level(src_lvl), .fast_pulse_output_pin(fp), .relay_one_output(r1), .relay_two_output(r2),
    .open_collector_output(oc), .analog_out_one(ao1), .analog_out_two(ao2));

  odm_term_load u_load (.pclk(pclk), .fast_pin(fp), .relay_one(r1), .relay_two(r2), .open_coll(oc),
    .closed(closed));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      fail_count++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Drives the cause of one selector code just across its threshold, or just short of it.
  task automatic apply(input logic [5:0] c, input logic on);
    @(posedge pclk);
    hours <= (c == SEL_PWR_ON && on) ? 16'h0065 : 16'h0064;
    run_now <= (c == SEL_TIMING) ? (on ? 16'h0032 : 16'h0031) : (c == SEL_RUN_TIME) ? (on ? 16'h00C9 : 16'h00C8) : 16'h0;
    ain <= (c == SEL_AI_WIN && on) ? 10'h385 : 10'h384;
    mod_t <= (c == SEL_MOD_TEMP && on) ? 8'h50 : 8'h4F;
    mot_t <= (c == SEL_MOT_HOT && on) ? 8'h5A : 8'h59;
    flags <= {on && c == SEL_LOW_HOLD, on && c == SEL_REVERSE, on && (c == SEL_LOAD0 || c == SEL_ALARM),
      on && c == SEL_CUR2, on && c == SEL_CUR1, on && c == SEL_FREQ2, on && c == SEL_FREQ1};
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    check("reset ao", {ao1, ao2}, 20'h0);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    foreach (RST[k]) begin
      apb(1'b0, RST[k].a, 32'h0);
      check("reset reg", rd, RST[k].v);
    end
    apb(1'b1, OFF_CTRL, 32'h2);
    apb(1'b1, OFF_PWR_TH, 32'h64);
    apb(1'b1, OFF_T_DUR, 32'h32);
    apb(1'b1, OFF_R_LIM, 32'hC8);
    apb(1'b1, OFF_AI_WIN, 32'h03840064);
    apb(1'b1, OFF_TEMP, 32'h5A50);
    foreach (ROWS[k]) begin
      apb(1'b1, OFF_SEL, {2'h0, ROWS[k].code, 24'h000200});
      apply(ROWS[k].code, 1'b0);
      repeat (4) @(posedge pclk);
      check("term off", closed[3], 1'b0);
      apply(ROWS[k].code, 1'b1);
      repeat (4) @(posedge pclk);
      check("term on", closed[3], ROWS[k].exp);
      check("term on", closed[3], ROWS[k].exp);
    end
    // The stopped state alone must hold code 37 on; the reverse stimulus also raises the stopped input.
    apb(1'b1, OFF_SEL, {2'h0, SEL_LOW_HOLD, 24'h000200});
    apply(SEL_REVERSE, 1'b1);
    repeat (4) @(posedge pclk);
    check("stopped hold", closed[3], 1'b1);
    apply(SEL_NONE, 1'b0);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, OFF_POL, 32'h1 << (4 * k));
      repeat (4) @(posedge pclk);
      check("polarity", closed, 4'h1 << k);
    end
    apb(1'b1, OFF_POL, 32'h0);
    apb(1'b1, OFF_SEL, {2'h0, SEL_REVERSE, 24'h000200});
    apb(1'b1, OFF_DLY3, 32'h3);
    apply(SEL_REVERSE, 1'b1);
    repeat (2) @(posedge pclk);
    apply(SEL_REVERSE, 1'b0);
    repeat (16) begin
      @(posedge pclk);
      check("reverted", oc, 1'b0);
    end
    apply(SEL_REVERSE, 1'b1);
    for (n = 0; n < 40 && oc !== 1'b1; n++) @(posedge pclk);
    check("delay", n >= 3 * TICK - TICK && n <= 3 * TICK + 3, 1'b1);
    apb(1'b1, OFF_SRC, 32'hF8);
    foreach (AOS[k]) begin
      apb(1'b1, OFF_AO1, AOS[k].cfg);
      apb(1'b1, OFF_AO2, AOS[k].cfg);
      @(posedge pclk);
      src_lvl[80 +: 10] <= AOS[k].x;
      src_lvl[150 +: 10] <= AOS[k].x;
      repeat (3) @(posedge pclk);
      check("analog", {ao1, ao2}, {AOS[k].y, AOS[k].y});
    end
    apb(1'b1, OFF_FMAX, 32'h0);
    apb(1'b0, OFF_FMAX, 32'h0);
    check("fmax low", rd, 32'h1);
    apb(1'b1, OFF_FMAX, 32'h4E20);
    apb(1'b0, OFF_FMAX, 32'h0);
    check("fmax high", rd, 32'h2710);
    apb(1'b0, 8'h44, 32'h0);
    check("unmapped err", err, 1'b1);
    check("unmapped data", rd, 32'h0);
    // Pulse mode at full source level: one period of 100 kHz is 1250 clocks.
    apb(1'b1, OFF_CTRL, 32'h3);
    src_lvl[9:0] <= 10'h3E8;
    for (n = 0; n < 3000 && fp !== 1'b1; n++) @(posedge pclk);
    for (n = 0; n < 3000 && fp !== 1'b0; n++) @(posedge pclk);
    for (n = 0; n < 3000 && fp !== 1'b1; n++) @(posedge pclk);
    m = n;
    for (n = 0; n < 3000 && fp !== 1'b0; n++) @(posedge pclk);
    check("pulse period", m + n >= 1245 && m + n <= 1255, 1'b1);
    // A reset in mid-run clears every output and restores the defaults.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    check("mid reset", {fp, r1, r2, oc, ao1, ao2}, 24'h0);
    presetn <= 1'b1;
    apb(1'b0, OFF_FMAX, 32'h0);
    check("fmax after reset", rd, 32'h1388);
    conclude();
  end
endmodule
`default_nettype wire
